// file: verilog/pc_card_window_pkg.sv
/*
  Constants, indices and carriers of the card window controller.
  Assumes one clock; byte address = index * 4.
*/
package pc_card_window_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_IO_A0_START  = 8'h00;
  localparam logic [7:0] IDX_IO_A0_END    = 8'h01;
  localparam logic [7:0] IDX_IO_A0_UPPER  = 8'h02;
  localparam logic [7:0] IDX_IO_A1_START  = 8'h03;
  localparam logic [7:0] IDX_IO_A1_END    = 8'h04;
  localparam logic [7:0] IDX_IO_A1_UPPER  = 8'h05;
  localparam logic [7:0] IDX_VPP_A_ADDR   = 8'h07;
  localparam logic [7:0] IDX_DATA_WIDTH   = 8'h0a;
  localparam logic [7:0] IDX_B_STATUS     = 8'h0c;
  localparam logic [7:0] IDX_IO_B0_START  = 8'h10;
  localparam logic [7:0] IDX_IO_B0_END    = 8'h11;
  localparam logic [7:0] IDX_IO_B0_UPPER  = 8'h12;
  localparam logic [7:0] IDX_IO_B1_START  = 8'h13;
  localparam logic [7:0] IDX_IO_B1_END    = 8'h14;
  localparam logic [7:0] IDX_IO_B1_UPPER  = 8'h15;
  localparam logic [7:0] IDX_VPP_B_ADDR   = 8'h17;
  localparam logic [7:0] IDX_WIN_A_EXT    = 8'h67;
  localparam logic [7:0] IDX_PAGE_EXT1    = 8'h6c;
  localparam logic [7:0] IDX_PAGE_ADDR    = 8'h6d;
  localparam logic [7:0] IDX_PAGE_EXT2    = 8'h6e;
  localparam logic [7:0] IDX_REG_A_ADDR   = 8'h8a;
  localparam logic [7:0] IDX_REG_B_ADDR   = 8'h9e;
  localparam logic [7:0] IDX_A_STATUS     = 8'ha2;
  localparam logic [7:0] IDX_STATUS_CHG   = 8'ha6;
  localparam logic [7:0] IDX_WIN_A_SOCKET = 8'ha8;
  localparam logic [7:0] IDX_WIN_B_SOCKET = 8'ha9;
  localparam logic [7:0] IDX_UPPER_CTL1   = 8'hb5;
  localparam logic [7:0] IDX_UPPER_CTL2   = 8'hb6;
  localparam logic [7:0] IDX_UPPER_CTL3   = 8'hb7;
  localparam logic [7:0] IDX_SOCKET_CFG   = 8'hc0;
  localparam logic [7:0] IDX_WIN_ENABLE   = 8'hc1;
  localparam logic [7:0] IDX_TIMING       = 8'hc2;
  localparam logic [7:0] IDX_CHG_ENABLE   = 8'hc3;
  localparam logic [7:0] IDX_WIN_A_START  = 8'hc4;
  localparam logic [7:0] IDX_WIN_A_END    = 8'hc5;
  localparam logic [7:0] IDX_WIN_B_START  = 8'hc6;
  localparam logic [7:0] IDX_WIN_B_END    = 8'hc7;
  localparam logic [7:0] IDX_WIN_B_PAGE   = 8'hc8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SOCK_SEL_BIT    = 0;  // window socket select: 0 = A, 1 = B
  localparam int SOCK_ASSIGN_BIT = 1;  // window socket select: window assigned
  localparam int CFG_IO_A_BIT    = 0;  // socket config: socket A is an I/O card
  localparam int CFG_IO_B_BIT    = 1;
  localparam int CFG_IOEN_LSB    = 2;  // four I/O window enables A0 A1 B0 B1
  localparam int TIM_W8_LSB      = 0;  // 3-bit wait count, 8-bit cycles
  localparam int TIM_W16_LSB     = 3;  // 3-bit wait count, 16-bit cycles
  localparam int TIM_DELAY_BIT   = 6;  // command delay for 8-bit cycles
  localparam int PAGE_ADDR_W     = 7;
  localparam int CHG_PER_SOCKET  = 4;  // cd change, rdy rise, bvd1 fall, bvd2 fall
  localparam int CHG_B_LSB       = 4;

  localparam logic [7:0] RESET_ZERO    = 8'h00;
  localparam logic [1:0] SYS_PAGE_HIGH = 2'h0;  // windows decode in low 4 Mbyte

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        mem_rd;
    logic        mem_wr;
    logic        io_rd;
    logic        io_wr;
    logic        byte_high;
    logic [23:0] addr;
    logic [7:0]  data;
  } sys_req_type;

  typedef struct packed {
    logic card_detect;
    logic ready;
    logic write_protect;
    logic bvd1;
    logic bvd2;
  } card_pins_type;

  typedef struct packed {
    logic card_enable_even_n;
    logic card_enable_odd_n;
    logic attribute_select_n;
    logic voltage_select;
  } card_ctl_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DELAY = 3'b001,
    ST_CMD   = 3'b010,
    ST_WAIT  = 3'b011,
    ST_DONE  = 3'b100
  } cycle_state_type;

endpackage : pc_card_window_pkg

// file: verilog/pc_card_window_controller.sv
/*
  Two-socket PC card window controller: APB registers,
  memory and I/O window decode, card cycle sequencer,
  status latches, VPP and REG pin control.
  Assumes sys_req on pclk, held until sys_ready;
  card pins are asynchronous and synchronised here.
*/

module pc_card_window_controller
  import pc_card_window_pkg::*;
#(
  parameter logic [7:0] CTL_IO_PAGE = 8'h00  // high byte of VPP and REG control addresses
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire sys_req_type   sys_req,
  output logic               sys_ready,
  input  wire card_pins_type socket_a_pins,
  input  wire card_pins_type socket_b_pins,
  input  wire logic          shared_card_wait_input_n,
  output card_ctl_type       socket_a_ctl,
  output card_ctl_type       socket_b_ctl,
  output logic      [25:0]   card_addr,
  output logic               mem_rd_n,
  output logic               mem_wr_n,
  output logic               io_rd_n,
  output logic               io_wr_n,
  output logic               status_irq
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] cfg_reg [0:255];
  logic [7:0] status_change_reg;
  logic [7:0] reg_index;
  logic       apb_access;
  logic       apb_commit;

  function automatic logic is_mapped(input logic [7:0] idx);
    case (idx)
      IDX_IO_A0_START, IDX_IO_A0_END, IDX_IO_A0_UPPER, IDX_IO_A1_START,
      IDX_IO_A1_END, IDX_IO_A1_UPPER, IDX_VPP_A_ADDR, IDX_DATA_WIDTH,
      IDX_B_STATUS, IDX_IO_B0_START, IDX_IO_B0_END, IDX_IO_B0_UPPER,
      IDX_IO_B1_START, IDX_IO_B1_END, IDX_IO_B1_UPPER, IDX_VPP_B_ADDR,
      IDX_WIN_A_EXT, IDX_PAGE_EXT1, IDX_PAGE_ADDR, IDX_PAGE_EXT2,
      IDX_REG_A_ADDR, IDX_REG_B_ADDR, IDX_A_STATUS, IDX_STATUS_CHG,
      IDX_WIN_A_SOCKET, IDX_WIN_B_SOCKET, IDX_UPPER_CTL1, IDX_UPPER_CTL2,
      IDX_UPPER_CTL3, IDX_SOCKET_CFG, IDX_WIN_ENABLE, IDX_TIMING,
      IDX_CHG_ENABLE, IDX_WIN_A_START, IDX_WIN_A_END, IDX_WIN_B_START,
      IDX_WIN_B_END, IDX_WIN_B_PAGE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // status registers are not storage
  function automatic logic is_storage(input logic [7:0] idx);
    is_storage = is_mapped(idx) && idx != IDX_A_STATUS && idx != IDX_B_STATUS && idx != IDX_STATUS_CHG;
  endfunction : is_storage

  function automatic logic [7:0] pin_status(input card_pins_type p);
    pin_status = {3'h0, p.bvd2, p.bvd1, p.write_protect, p.ready, p.card_detect};
  endfunction : pin_status

  assign reg_index  = paddr[9:2];
  assign apb_access = psel && penable && !pready;
  // writes land where pready is high
  assign apb_commit = psel && penable && pready;

  logic addr_ok;
  assign addr_ok = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'h0) && is_mapped(reg_index);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++) begin
        cfg_reg[i] <= RESET_ZERO;
      end
    end else if (apb_commit && pwrite && addr_ok && is_storage(reg_index)) begin
      cfg_reg[reg_index] <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  card_pins_type pins_a_meta, pins_b_meta, pins_a_sync, pins_b_sync, pins_a_prev, pins_b_prev;
  logic          wait_meta, wait_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_a_meta <= '0;
      pins_b_meta <= '0;
      pins_a_sync <= '0;
      pins_b_sync <= '0;
      pins_a_prev <= '0;
      pins_b_prev <= '0;
      wait_meta   <= 1'b1;
      wait_sync   <= 1'b1;
    end else begin
      pins_a_meta <= socket_a_pins;
      pins_b_meta <= socket_b_pins;
      pins_a_sync <= pins_a_meta;
      pins_b_sync <= pins_b_meta;
      pins_a_prev <= pins_a_sync;
      pins_b_prev <= pins_b_sync;
      wait_meta   <= shared_card_wait_input_n;
      wait_sync   <= wait_meta;
    end
  end

  // ----------------------------------------------------------------
  // status change latches
  // ----------------------------------------------------------------
  function automatic logic [CHG_PER_SOCKET-1:0] pin_events(input card_pins_type now, input card_pins_type was);
    pin_events = {was.bvd2 && !now.bvd2, was.bvd1 && !now.bvd1,
                  now.ready && !was.ready, now.card_detect != was.card_detect};
  endfunction : pin_events

  logic [7:0] change_set;
  logic [7:0] change_clear;
  assign change_set   = {pin_events(pins_b_sync, pins_b_prev), pin_events(pins_a_sync, pins_a_prev)};
  assign change_clear = (apb_commit && pwrite && addr_ok && reg_index == IDX_STATUS_CHG) ? pwdata[7:0] : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_change_reg <= RESET_ZERO;
    end else begin
      // set wins over a same-cycle clear
      status_change_reg <= (status_change_reg & ~change_clear) | change_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_irq <= 1'b0;
    end else begin
      // holds until enabled bits are cleared
      status_irq <= |(status_change_reg & cfg_reg[IDX_CHG_ENABLE]);
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  logic [7:0] read_byte;
  always_comb begin
    case (reg_index)
      IDX_A_STATUS:   read_byte = pin_status(pins_a_sync);
      IDX_B_STATUS:   read_byte = pin_status(pins_b_sync);
      IDX_STATUS_CHG: read_byte = status_change_reg;
      default:        read_byte = cfg_reg[reg_index];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access && !addr_ok;
      if (apb_access) begin
        prdata <= (addr_ok && !pwrite) ? {24'h0, read_byte} : 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // memory window decode
  // ----------------------------------------------------------------
  logic [7:0] sys_page;
  logic [1:0] mem_win_hit;
  logic [1:0] win_socket;
  logic       sock_is_io [0:1];
  logic       sock_is_16 [0:1];

  assign sys_page      = sys_req.addr[21:14];
  assign sock_is_io[0] = cfg_reg[IDX_SOCKET_CFG][CFG_IO_A_BIT];
  assign sock_is_io[1] = cfg_reg[IDX_SOCKET_CFG][CFG_IO_B_BIT];
  assign sock_is_16[0] = cfg_reg[IDX_DATA_WIDTH][0];
  assign sock_is_16[1] = cfg_reg[IDX_DATA_WIDTH][1];

  generate
    for (genvar w = 0; w < 2; w++) begin : g_mem_win
      logic [7:0] start_idx, end_idx, sel_idx;
      assign start_idx     = w ? IDX_WIN_B_START : IDX_WIN_A_START;
      assign end_idx       = w ? IDX_WIN_B_END : IDX_WIN_A_END;
      assign sel_idx       = w ? IDX_WIN_B_SOCKET : IDX_WIN_A_SOCKET;
      assign win_socket[w] = cfg_reg[sel_idx][SOCK_SEL_BIT];
      // an I/O socket is no memory card
      assign mem_win_hit[w] = sys_req.addr[23:22] == SYS_PAGE_HIGH
                              && sys_page >= cfg_reg[start_idx] && sys_page <= cfg_reg[end_idx]
                              && cfg_reg[IDX_WIN_ENABLE][w] && cfg_reg[sel_idx][SOCK_ASSIGN_BIT]
                              && !sock_is_io[win_socket[w]];
    end
  endgenerate

  // window A wins when both hit
  logic        mem_hit;
  logic        mem_win;
  logic        mem_sock;
  logic [25:0] mem_card_addr;
  assign mem_hit  = |mem_win_hit;
  assign mem_win  = !mem_win_hit[0];
  assign mem_sock = win_socket[mem_win];

  always_comb begin
    if (!mem_win) begin
      mem_card_addr = {cfg_reg[IDX_UPPER_CTL1][1:0], cfg_reg[IDX_PAGE_EXT1][0],
                       cfg_reg[IDX_WIN_A_EXT][1:0], cfg_reg[IDX_PAGE_ADDR][PAGE_ADDR_W-1:0],
                       sys_req.addr[13:0]};
    end else begin
      mem_card_addr = {cfg_reg[IDX_UPPER_CTL1][3:2], cfg_reg[IDX_PAGE_EXT1][1],
                       cfg_reg[IDX_PAGE_EXT2][1:0], cfg_reg[IDX_WIN_B_PAGE][PAGE_ADDR_W-1:0],
                       sys_req.addr[13:0]};
    end
  end

  // ----------------------------------------------------------------
  // I/O window decode
  // ----------------------------------------------------------------
  logic [3:0] io_win_hit;
  generate
    for (genvar k = 0; k < 4; k++) begin : g_io_win
      localparam logic [7:0] BASE = (k < 2) ? IDX_IO_A0_START : IDX_IO_B0_START;
      logic [7:0] lo_idx;
      assign lo_idx = BASE + 8'(3 * (k % 2));
      // shared high byte: no 256-byte crossing
      assign io_win_hit[k] = sys_req.addr[7:0] >= cfg_reg[lo_idx]
                             && sys_req.addr[7:0] <= cfg_reg[lo_idx + 8'h01]
                             && sys_req.addr[15:8] == cfg_reg[lo_idx + 8'h02]
                             && cfg_reg[IDX_SOCKET_CFG][CFG_IOEN_LSB + k]
                             && sock_is_io[k / 2];
    end
  endgenerate

  logic io_hit;
  logic io_sock;
  assign io_hit  = |io_win_hit;
  assign io_sock = !(|io_win_hit[1:0]);

  // ----------------------------------------------------------------
  // VPP and REG control writes
  // ----------------------------------------------------------------
  logic sys_io_wr_prev;
  logic io_wr_start;
  logic vpp_reg [0:1];
  logic reg_state [0:1];
  assign io_wr_start = sys_req.io_wr && !sys_io_wr_prev && sys_req.addr[15:8] == CTL_IO_PAGE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_io_wr_prev <= 1'b0;
    end else begin
      sys_io_wr_prev <= sys_req.io_wr;
    end
  end

  generate
    for (genvar s = 0; s < 2; s++) begin : g_pin_ctl
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          vpp_reg[s]   <= 1'b0;
          reg_state[s] <= 1'b1;
        end else if (io_wr_start) begin
          if (sys_req.addr[7:0] == cfg_reg[s ? IDX_VPP_B_ADDR : IDX_VPP_A_ADDR]) begin
            vpp_reg[s] <= sys_req.data[0];
          end
          if (sys_req.addr[7:0] == cfg_reg[s ? IDX_REG_B_ADDR : IDX_REG_A_ADDR]) begin
            reg_state[s] <= sys_req.data[0];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // card cycle sequencer
  // ----------------------------------------------------------------
  cycle_state_type state_reg;
  logic [2:0]      wait_count_reg;
  logic            cur_sock_reg;
  logic            cur_io_reg;
  logic            cur_write_reg;
  logic            cur_even_reg;
  logic            cur_odd_reg;
  logic            start_req;
  logic            start_sock;
  logic            start_16;

  assign start_req  = (sys_req.mem_rd || sys_req.mem_wr) ? mem_hit : ((sys_req.io_rd || sys_req.io_wr) && io_hit);
  assign start_sock = (sys_req.mem_rd || sys_req.mem_wr) ? mem_sock : io_sock;
  assign start_16   = sock_is_16[start_sock];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ST_IDLE;
      wait_count_reg <= 3'h0;
      cur_sock_reg   <= 1'b0;
      cur_io_reg     <= 1'b0;
      cur_write_reg  <= 1'b0;
      cur_even_reg   <= 1'b0;
      cur_odd_reg    <= 1'b0;
      card_addr      <= 26'h0;
      sys_ready      <= 1'b0;
    end else begin
      sys_ready <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_req) begin
            // memory decode wins over I/O
            cur_sock_reg  <= start_sock;
            cur_io_reg    <= !(sys_req.mem_rd || sys_req.mem_wr);
            cur_write_reg <= sys_req.mem_wr || sys_req.io_wr;
            card_addr     <= (sys_req.mem_rd || sys_req.mem_wr) ? mem_card_addr
                             : {10'h0, sys_req.addr[15:0]};
            // 8-bit: even enable only
            cur_even_reg  <= start_16 ? !sys_req.addr[0] : 1'b1;
            cur_odd_reg   <= start_16 && sys_req.byte_high;
            wait_count_reg <= start_16 ? cfg_reg[IDX_TIMING][TIM_W16_LSB +: 3]
                              : cfg_reg[IDX_TIMING][TIM_W8_LSB +: 3];
            state_reg <= (!start_16 && cfg_reg[IDX_TIMING][TIM_DELAY_BIT]) ? ST_DELAY : ST_CMD;
          end
        end
        ST_DELAY: state_reg <= ST_CMD;
        ST_CMD: begin
          if (wait_count_reg == 3'h0) begin
            state_reg <= ST_WAIT;
          end else begin
            wait_count_reg <= wait_count_reg - 3'h1;
          end
        end
        ST_WAIT: begin
          // low shared wait stretches the command
          if (wait_sync) begin
            state_reg <= ST_DONE;
            sys_ready <= 1'b1;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // card pin drive
  // ----------------------------------------------------------------
  logic sel_active;
  logic cmd_active;
  assign sel_active = state_reg == ST_DELAY || state_reg == ST_CMD || state_reg == ST_WAIT;
  assign cmd_active = (state_reg == ST_CMD || state_reg == ST_WAIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rd_n <= 1'b1;
      mem_wr_n <= 1'b1;
      io_rd_n  <= 1'b1;
      io_wr_n  <= 1'b1;
    end else begin
      mem_rd_n <= !(cmd_active && !cur_io_reg && !cur_write_reg);
      mem_wr_n <= !(cmd_active && !cur_io_reg && cur_write_reg);
      io_rd_n  <= !(cmd_active && cur_io_reg && !cur_write_reg);
      io_wr_n  <= !(cmd_active && cur_io_reg && cur_write_reg);
    end
  end

  generate
    for (genvar s = 0; s < 2; s++) begin : g_sock_out
      card_ctl_type ctl_next;
      card_ctl_type ctl_reg;
      logic         mine;
      assign mine = sel_active && cur_sock_reg == 1'(s);
      always_comb begin
        ctl_next.card_enable_even_n = !(mine && cur_even_reg);
        ctl_next.card_enable_odd_n  = !(mine && cur_odd_reg);
        // idle sockets keep REG high; I/O forces it low
        ctl_next.attribute_select_n = mine ? (!cur_io_reg && reg_state[s]) : 1'b1;
        ctl_next.voltage_select     = vpp_reg[s];
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctl_reg <= '{card_enable_even_n: 1'b1, card_enable_odd_n: 1'b1,
                       attribute_select_n: 1'b1, voltage_select: 1'b0};
        end else begin
          ctl_reg <= ctl_next;
        end
      end
      if (s == 0) begin : g_a
        assign socket_a_ctl = ctl_reg;
      end else begin : g_b
        assign socket_b_ctl = ctl_reg;
      end
    end
  endgenerate

endmodule : pc_card_window_controller

// file: tb/pc_card_partner.sv
/* card side model: two cards, wait lines ANDed.
   assumes stall from the bench, enables from the controller. */
module pc_card_partner
  import pc_card_window_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         stall,
  input  wire card_ctl_type a_ctl,
  input  wire card_ctl_type b_ctl,
  output logic              wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] age_a = 3'h0;
  logic [2:0] age_b = 3'h0;
  // wait held 4 cycles per enable, so a stretched cycle ends
  always @(posedge pclk) begin
    age_a <= a_ctl.card_enable_even_n ? 3'h0 : age_a + {2'h0, age_a != 3'h7};
    age_b <= b_ctl.card_enable_even_n ? 3'h0 : age_b + {2'h0, age_b != 3'h7};
  end
  assign wait_n = !(stall && !a_ctl.card_enable_even_n && age_a < 3'h4)
                & !(stall && !b_ctl.card_enable_even_n && age_b < 3'h4);
endmodule : pc_card_partner

// file: tb/pc_card_window_monitor.sv
/* checker on controller ports: apb, card cycle, socket drive.
   assumes one clock, pclk. */
module pc_card_window_monitor
  import pc_card_window_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         sys_ready,
  input wire card_ctl_type socket_a_ctl,
  input wire card_ctl_type socket_b_ctl,
  input wire logic         mem_rd_n,
  input wire logic         mem_wr_n,
  input wire logic         io_rd_n,
  input wire logic         io_wr_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire io_cmd = !io_rd_n || !io_wr_n;
  wire cmd    = !mem_rd_n || !mem_wr_n || io_cmd;
  wire en_a   = !socket_a_ctl.card_enable_even_n || !socket_a_ctl.card_enable_odd_n;
  wire en_b   = !socket_b_ctl.card_enable_even_n || !socket_b_ctl.card_enable_odd_n;
  wire en_any = en_a || en_b;
  sequence cmd_on; $rose(cmd); endsequence
  sequence cycle_end; ##[1:40] sys_ready; endsequence
  apb_wait_a: assert property (psel && $rose(penable) |=> pready) else $error("pready late");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  ready_pulse_a: assert property (sys_ready |=> !sys_ready) else $error("sys_ready too long");
  one_socket_a: assert property (!(en_a && en_b)) else $error("both sockets enabled");
  cmd_enabled_a: assert property (cmd |-> en_any) else $error("command with no card");
  cycle_bound_a: assert property (cmd_on |-> cycle_end) else $error("card cycle hung");
  io_reg_a: assert property (io_cmd |-> (en_a && !socket_a_ctl.attribute_select_n)
    || (en_b && !socket_b_ctl.attribute_select_n)) else $error("reg not low on io");
  ready_after_a: assert property (sys_ready |-> $past(en_any)) else $error("ready with no cycle");
endmodule : pc_card_window_monitor
bind pc_card_window_controller pc_card_window_monitor mon (.*);

// file: tb/pc_card_window_controller_test.sv
/* self-checking bench: registers, windows, pin control, status.
   assumes the partner model and the bound checker. */
module pc_card_window_controller_test
  import pc_card_window_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;
  logic pready, pslverr, sys_ready, wait_n, mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, status_irq;
  logic hit, sa, sb, ra, rb, err;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd, seed = 32'hccca0e87;
  logic [25:0] card_addr, ca;
  logic [7:0] idx [17] = '{IDX_UPPER_CTL1, IDX_PAGE_EXT1, IDX_WIN_A_EXT, IDX_PAGE_ADDR, IDX_PAGE_EXT2,
    IDX_WIN_B_PAGE, IDX_WIN_ENABLE, IDX_WIN_A_START, IDX_WIN_A_END, IDX_WIN_B_START, IDX_WIN_B_END,
    IDX_WIN_A_SOCKET, IDX_WIN_B_SOCKET, IDX_DATA_WIDTH, IDX_VPP_A_ADDR, IDX_REG_A_ADDR, IDX_CHG_ENABLE};
  logic [7:0] v [17] = '{0, 0, 0, 0, 0, 0, 8'h03, 8'h10, 8'h11, 8'h20, 8'h20, 8'h02, 8'h03, 8'h03,
    8'h3c, 8'h3d, 8'h01};
  logic [7:0] pg [4] = '{8'h11, 8'h20, 8'h12, 8'h0f};
  logic [4:0] ex [4] = '{5'b11010, 5'b10100, 5'h0, 5'h0};
  sys_req_type sys_req = '0, q;
  card_pins_type pins_a = '0, pins_b = '0;
  card_ctl_type a_ctl, b_ctl;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  always #5 pclk = ~pclk;
  pc_card_window_controller dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sys_req, .sys_ready, .socket_a_pins(pins_a), .socket_b_pins(pins_b),
    .shared_card_wait_input_n(wait_n), .socket_a_ctl(a_ctl), .socket_b_ctl(b_ctl), .card_addr,
    .mem_rd_n, .mem_wr_n, .io_rd_n, .io_wr_n, .status_irq);
  pc_card_partner cards (.pclk, .stall, .a_ctl, .b_ctl, .wait_n);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [25:0] xlat(input logic b, input logic [13:0] lo);
    return b ? {v[0][3:2], v[1][1], v[4][1:0], v[5][6:0], lo} : {v[0][1:0], v[1][0], v[2][1:0], v[3][6:0], lo};
  endfunction : xlat
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= {22'h0, a, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // a miss never answers: wait cut at 40 cycles
  task automatic sys(input sys_req_type r);
    @(posedge pclk);
    sys_req <= r;
    {sa, sb, ra, rb} = 4'h0;
    repeat (40) begin
      @(posedge pclk);
      sa |= !a_ctl.card_enable_even_n;
      sb |= !b_ctl.card_enable_even_n;
      ra |= !a_ctl.card_enable_even_n && !a_ctl.attribute_select_n;
      rb |= !b_ctl.card_enable_even_n && !b_ctl.attribute_select_n;
      ca = card_addr;
      if (sys_ready === 1'b1) break;
    end
    hit = (sys_ready === 1'b1);
    sys_req <= '0;
  endtask : sys
  always @(posedge pclk) if (++cyc == 8000) begin
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, IDX_PAGE_ADDR, 0);
    check(rd, 0);
    apb(0, 8'hff, 0);
    check({err, rd}, {1'b1, 32'h0});
    for (int i = 0; i < 17; i++) begin
      seed = lfsr(seed);
      if (i < 6) v[i] = seed[7:0];
      apb(1, idx[i], v[i]);
      apb(0, idx[i], 0);
      check(rd, v[i]);
    end
    sys('{io_wr: 1, addr: 24'h3d, default: 0});
    sys('{io_wr: 1, addr: 24'h3c, data: 8'h01, default: 0});
    check({a_ctl.voltage_select, b_ctl.voltage_select}, 2'b10);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      stall <= k[0];
      q = '{mem_rd: !k[0], mem_wr: k[0], addr: {2'h0, pg[k], seed[13:1], 1'b0}, default: 0};
      sys(q);
      check({hit, sa, sb, ra, rb}, ex[k]);
      if (k < 2) check(ca, xlat(k[0], q.addr[13:0]));
    end
    seed = lfsr(seed);
    v[0] = {1'b0, seed[6:1], 1'b0};
    apb(1, IDX_IO_A0_START, v[0]);
    apb(1, IDX_IO_A0_END, v[0] + 8'h10);
    apb(1, IDX_IO_A0_UPPER, seed[15:8]);
    for (int j = 0; j < 3; j++) begin
      apb(1, IDX_SOCKET_CFG, j == 2 ? 8'h04 : 8'h05);
      sys('{io_rd: 1, addr: {8'h0, seed[15:8], v[0] + 8'h10 + j[0]}, default: 0});
      check({hit, sa}, j == 0 ? 2'b11 : 2'b00);
      if (j == 0) check(ca[15:0], {seed[15:8], v[0] + 8'h10});
    end
    pins_a.card_detect <= 1;
    repeat (6) @(posedge pclk);
    apb(0, IDX_STATUS_CHG, 0);
    check({rd[0], status_irq}, 2'b11);
    apb(1, IDX_STATUS_CHG, 8'h01);
    apb(0, IDX_STATUS_CHG, 0);
    check({rd[0], status_irq}, 2'b00);
    give_verdict();
  end
endmodule : pc_card_window_controller_test
